//--- verilog/timeslot_capture_consts.vh
// Constants, register map and field layout of the time-slot sequencer and capture block
`ifndef TIMESLOT_CAPTURE_CONSTS_VH
`define TIMESLOT_CAPTURE_CONSTS_VH
`define ADDR_PRESCALER 16'h1040
`define ADDR_CAPCTL 16'h1044
`define ADDR_CAPFLAG 16'h1048
`define ADDR_BUFPTR 16'h104c
`define ADDR_CMDAREA 16'h1050
`define ADDR_TIMERS 16'h1054
`define ADDR_DED_BASE 16'h1080
`define ADDR_BUF_BASE 16'h1100
`define ADDR_CMD_BASE 16'h1200
`define DED_REGION 16'hfff0
`define MEM_REGION 16'hffc0
`define FAST_BIT 4
`define MODE_BIT 24
`define CP6BUF_BIT 25
`define RUN_BIT 16
`define LAST16_BIT 8
`define MASK_DED_A 6'h03
`define MASK_DED_B 6'h0f
`define MASK_BUF_A 6'h1c
`define MASK_BUF_B 6'h10
`define MASK_CP6 6'h20
`define COARSE_DIV 3'h7
`define OP_COMPARE 3'h0
`define OP_VTIMER 3'h1
`define OP_OFFSET 3'h2
`define OP_STEP 3'h3
`define OP_CAP16 3'h4
`define COST_ONE 9'h001
`define COST_TWO 9'h002
`define COST_THREE 9'h003
`define STEP_LAG 5'h02
`define TMR_ENABLE_BIT 3
`endif

//--- verilog/timeslot_prescaler_capture.v
// Time-slot command sequencer, timer prescaler and six-input capture unit
`timescale 1ns/10ps
`default_nettype none
`include "timeslot_capture_consts.vh"
module timeslot_prescaler_capture (
	input wire clk, // System clock, 200 MHz
	input wire rstn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB direction, high for write
	input wire [15:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire [5:0] capture_inputs, // Capture pins, bit 5 is the event input
	output reg cap_irq, // Level, any enabled capture flag set
	output reg slot_tick // Prescaler tick, one cycle
);
	localparam S_IDLE = 2'b01;
	localparam S_RUN = 2'b10;

	reg fast_sel;
	reg [3:0] div_val;
	reg [5:0] rise_en;
	reg [5:0] fall_en;
	reg [5:0] irq_en;
	reg [5:0] cap_flag;
	reg mode_b;
	reg cp6_buf;
	reg [4:0] buf_ptr;
	reg last16;
	reg [3:0] buf_last;
	reg [3:0] cmd_end;
	reg seq_run;
	reg [19:0] def_timer;
	reg [7:0] ev_cnt;
	reg ev_mark;
	reg ev_period;
	reg [31:0] ded_cap [0:3];
	reg [31:0] cbuf [0:15];
	reg [31:0] cmd_mem [0:15];
	reg [2:0] coarse_cnt;
	reg [3:0] fine_cnt;
	reg tick;
	reg [5:0] sync_a;
	reg [5:0] sync_b;
	reg [5:0] sync_c;
	reg [5:0] pin_lvl;
	reg [3:0] buf_pend;
	reg [1:0] state;
	reg [4:0] idx;
	reg [8:0] used;
	reg half_phase;
	reg step_valid;
	reg [4:0] step_at;

	// Slot budget per prescaled period, indexed by fast select and divide value
	function [8:0] slot_budget;
		input [4:0] sel;
		begin
			case (sel)
				5'h10, 5'h11: slot_budget = 9'h002;
				5'h12: slot_budget = 9'h005;
				5'h13: slot_budget = 9'h009;
				5'h14: slot_budget = 9'h00c;
				5'h15: slot_budget = 9'h00f;
				5'h16: slot_budget = 9'h013;
				5'h17: slot_budget = 9'h015;
				5'h18: slot_budget = 9'h019;
				5'h19: slot_budget = 9'h01d;
				5'h1a: slot_budget = 9'h01f;
				5'h1b: slot_budget = 9'h023;
				5'h1c: slot_budget = 9'h026;
				5'h1d: slot_budget = 9'h029;
				5'h1e: slot_budget = 9'h02d;
				5'h1f, 5'h00, 5'h01: slot_budget = 9'h030;
				5'h02: slot_budget = 9'h04a;
				5'h03: slot_budget = 9'h065;
				5'h04: slot_budget = 9'h07f;
				5'h05: slot_budget = 9'h099;
				5'h06: slot_budget = 9'h0b3;
				5'h07: slot_budget = 9'h0cd;
				5'h08: slot_budget = 9'h0e7;
				5'h09: slot_budget = 9'h101;
				5'h0a: slot_budget = 9'h11b;
				5'h0b: slot_budget = 9'h135;
				5'h0c: slot_budget = 9'h150;
				5'h0d: slot_budget = 9'h16a;
				5'h0e: slot_budget = 9'h185;
				default: slot_budget = 9'h19f;
			endcase
		end
	endfunction

	// Next circular buffer block, wrapping at the programmed length
	function [3:0] next_block;
		input [3:0] blk;
		input [3:0] last;
		begin
			next_block = (blk == last) ? 4'h0 : blk + 4'h1;
		end
	endfunction

	// Virtual or offset timer step: count field wraps past its maximum
	function [31:0] timer_step;
		input [31:0] ent;
		input clr;
		reg [11:0] cnt;
		begin
			cnt = ent[19:8] + 12'h001;
			if (clr || ent[19:8] >= ent[31:20])
				cnt = 12'h000;
			timer_step = {ent[31:20], cnt, ent[7:0]};
		end
	endfunction

	// Prescaler: coarse /1 or /8, then fine /(n+1), zero giving /2
	wire [3:0] fine_last = (div_val == 4'h0) ? 4'h1 : div_val;
	wire coarse_done = fast_sel || (coarse_cnt == `COARSE_DIV);
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			coarse_cnt <= 3'h0;
			fine_cnt <= 4'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			coarse_cnt <= coarse_done ? 3'h0 : coarse_cnt + 3'h1;
			if (coarse_done)
			begin
				if (fine_cnt >= fine_last)
				begin
					fine_cnt <= 4'h0;
					tick <= 1'b1;
				end
				else
					fine_cnt <= fine_cnt + 4'h1;
			end
		end
	end

	// Three-flop synchroniser; a level counts once second and third agree
	reg [5:0] new_lvl;
	reg [5:0] hit;
	reg [5:0] ded_mask;
	reg [5:0] buf_mask;
	always @*
	begin
		new_lvl = (~(sync_b ^ sync_c) & sync_c) | ((sync_b ^ sync_c) & pin_lvl);
		hit = (new_lvl & ~pin_lvl & rise_en) | (~new_lvl & pin_lvl & fall_en);
		ded_mask = mode_b ? `MASK_DED_B : `MASK_DED_A;
		buf_mask = (mode_b ? `MASK_BUF_B : `MASK_BUF_A) | (cp6_buf ? `MASK_CP6 : 6'h00);
	end

	// Sequencer view of the current entry
	wire [31:0] entry = cmd_mem[idx[3:0]];
	wire [2:0] opcode = entry[2:0];
	wire [8:0] cost = (opcode == `OP_VTIMER) ? `COST_TWO :
		(opcode == `OP_OFFSET) ? `COST_THREE : `COST_ONE;
	wire [4:0] last_idx = {1'b0, cmd_end} + {4'h0, step_valid};
	wire fits = (idx <= last_idx) && (used + cost <= slot_budget({fast_sel, div_val}));
	wire slow = step_valid && (idx >= step_at);
	wire run_now = state[1] && fits && (!slow || half_phase);
	wire cmd16 = run_now && (opcode == `OP_CAP16);
	wire tmr_op = run_now && entry[`TMR_ENABLE_BIT] &&
		(opcode == `OP_VTIMER || opcode == `OP_OFFSET);

	// Circular buffer write choice: command capture first, pins wait pending
	reg [3:0] pend_all;
	reg [1:0] pick;
	reg pin_wr;
	reg [3:0] wr_blk;
	reg [4:0] next_ptr;
	reg [31:0] wr_word;
	reg we_hi;
	reg we_lo;
	always @*
	begin
		pend_all = buf_pend | (hit[5:2] & buf_mask[5:2]);
		pick = pend_all[0] ? 2'd0 : pend_all[1] ? 2'd1 : pend_all[2] ? 2'd2 : 2'd3;
		pin_wr = !cmd16 && (pend_all != 4'h0);
		wr_blk = next_block(buf_ptr[4:1], buf_last);
		next_ptr = buf_ptr;
		wr_word = {ev_cnt, 4'h0, def_timer};
		wr_word[20 + pick] = 1'b1;
		we_hi = 1'b0;
		we_lo = 1'b0;
		if (cmd16)
		begin
			// 16-bit capture fills the next half-word
			next_ptr = buf_ptr[0] ? {wr_blk, 1'b0} : {buf_ptr[4:1], 1'b1};
			wr_blk = next_ptr[4:1];
			wr_word = {def_timer[15:0], def_timer[15:0]};
			we_hi = !next_ptr[0];
			we_lo = next_ptr[0];
		end
		else if (pin_wr)
		begin
			// A 32-bit capture reuses the block whose lower half holds the last 16-bit one
			if (buf_ptr[0] && last16)
				wr_blk = buf_ptr[4:1];
			next_ptr = {wr_blk, 1'b1};
			we_hi = 1'b1;
			we_lo = 1'b1;
		end
	end

	// APB decode
	wire setup = psel && !penable;
	wire wr_go = psel && penable && pready && pwrite && !pslverr;
	wire is_ded = ((paddr & `DED_REGION) == `ADDR_DED_BASE);
	wire is_buf = (paddr & `MEM_REGION) == `ADDR_BUF_BASE;
	wire is_cmd = (paddr & `MEM_REGION) == `ADDR_CMD_BASE;
	reg [31:0] rd_data;
	reg addr_ok;
	always @*
	begin
		rd_data = 32'h0000_0000;
		addr_ok = 1'b1;
		if (paddr[1:0] != 2'b00)
			addr_ok = 1'b0;
		else if (paddr == `ADDR_PRESCALER)
			rd_data = {27'h000_0000, fast_sel, div_val};
		else if (paddr == `ADDR_CAPCTL)
			rd_data = {6'h00, cp6_buf, mode_b, 2'h0, irq_en, 2'h0, fall_en, 2'h0, rise_en};
		else if (paddr == `ADDR_CAPFLAG)
			rd_data = {26'h000_0000, cap_flag};
		else if (paddr == `ADDR_BUFPTR)
			rd_data = {23'h00_0000, last16, 3'h0, buf_ptr};
		else if (paddr == `ADDR_CMDAREA)
			rd_data = {15'h0000, seq_run, 4'h0, cmd_end, 4'h0, buf_last};
		else if (paddr == `ADDR_TIMERS)
			rd_data = {ev_cnt, 4'h0, def_timer};
		else if (is_ded)
			rd_data = ded_cap[paddr[3:2]];
		else if (is_buf)
			rd_data = cbuf[paddr[5:2]];
		else if (is_cmd)
			rd_data = cmd_mem[paddr[5:2]];
		else
			addr_ok = 1'b0;
	end

	// Bus answer: data latched in setup, ready for exactly one access cycle
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= rd_data;
			pready <= 1'b1;
			pslverr <= !addr_ok;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control registers written by software
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fast_sel <= 1'b0;
			div_val <= 4'h0;
			rise_en <= 6'h00;
			fall_en <= 6'h00;
			irq_en <= 6'h00;
			mode_b <= 1'b0;
			cp6_buf <= 1'b0;
			buf_last <= 4'hf;
			cmd_end <= 4'h0;
			seq_run <= 1'b0;
		end
		else if (wr_go)
		begin
			if (paddr == `ADDR_PRESCALER)
			begin
				fast_sel <= pwdata[`FAST_BIT];
				div_val <= pwdata[3:0];
			end
			if (paddr == `ADDR_CAPCTL)
			begin
				rise_en <= pwdata[5:0];
				fall_en <= pwdata[13:8];
				irq_en <= pwdata[21:16];
				mode_b <= pwdata[`MODE_BIT];
				cp6_buf <= pwdata[`CP6BUF_BIT];
			end
			if (paddr == `ADDR_CMDAREA)
			begin
				buf_last <= pwdata[3:0];
				cmd_end <= pwdata[11:8];
				seq_run <= pwdata[`RUN_BIT];
			end
		end
	end

	// Pins, flags, pointer, timers; hardware events win over software clears
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_a <= 6'h00;
			sync_b <= 6'h00;
			sync_c <= 6'h00;
			pin_lvl <= 6'h00;
			cap_flag <= 6'h00;
			buf_pend <= 4'h0;
			buf_ptr <= 5'h1f;
			last16 <= 1'b0;
			def_timer <= 20'h0_0000;
			ev_cnt <= 8'h00;
			ev_mark <= 1'b0;
			ev_period <= 1'b0;
			cap_irq <= 1'b0;
			slot_tick <= 1'b0;
		end
		else
		begin
			sync_a <= capture_inputs;
			sync_b <= sync_a;
			sync_c <= sync_b;
			pin_lvl <= new_lvl;
			slot_tick <= tick;
			cap_flag <= (cap_flag & ~(wr_go && paddr == `ADDR_CAPFLAG ? pwdata[5:0] : 6'h00))
				| hit;
			cap_irq <= |(cap_flag & irq_en);
			buf_pend <= pin_wr ? pend_all & ~(4'h1 << pick) : pend_all;
			if (cmd16 || pin_wr)
			begin
				buf_ptr <= next_ptr;
				last16 <= cmd16;
			end
			else if (wr_go && paddr == `ADDR_BUFPTR)
				buf_ptr <= pwdata[4:0];
			if (tick)
				def_timer <= def_timer + 20'h0_0001;
			if (hit[5])
				ev_cnt <= ev_cnt + 8'h01;
			if (tick)
			begin
				ev_period <= ev_mark || hit[5];
				ev_mark <= 1'b0;
			end
			else if (hit[5])
				ev_mark <= 1'b1;
		end
	end

	// Dedicated captures: inputs 0 and 1 own fixed locations, and 2 and 3 too when mode_b is set
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ded_cap[0] <= 32'h0000_0000;
			ded_cap[1] <= 32'h0000_0000;
			ded_cap[2] <= 32'h0000_0000;
			ded_cap[3] <= 32'h0000_0000;
		end
		else
		begin
			if (hit[0] && ded_mask[0])
				ded_cap[0] <= {ev_cnt, 4'h0, def_timer};
			if (hit[1] && ded_mask[1])
				ded_cap[1] <= {ev_cnt, 4'h0, def_timer};
			if (hit[2] && ded_mask[2])
				ded_cap[2] <= {ev_cnt, 4'h1, def_timer};
			if (hit[3] && ded_mask[3])
				ded_cap[3] <= {ev_cnt, 4'h2, def_timer};
		end
	end

	// Sequencer: one entry per clock, walking up from entry zero each period
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= S_IDLE;
			idx <= 5'h00;
			used <= 9'h000;
			half_phase <= 1'b0;
			step_valid <= 1'b0;
			step_at <= 5'h00;
		end
		else
		begin
			case (state)
				S_IDLE:
				begin
					if (tick && seq_run)
					begin
						state <= S_RUN;
						idx <= 5'h00;
						used <= 9'h000;
						half_phase <= !half_phase;
					end
				end
				S_RUN:
				begin
					// Budget or area exhausted ends the period's walk
					if (!fits || tick)
						state <= S_IDLE;
					else
					begin
						idx <= idx + 5'h01;
						used <= used + cost;
						// Only the first step entry counts
						if (run_now && opcode == `OP_STEP && !step_valid)
						begin
							step_valid <= 1'b1;
							step_at <= idx + `STEP_LAG;
						end
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	// Memories: timers write back in place; capture owns the buffer port
	always @(posedge clk)
	begin
		if (tmr_op)
			cmd_mem[idx[3:0]] <= timer_step(entry,
				opcode == `OP_OFFSET && ev_period);
		else if (wr_go && is_cmd)
			cmd_mem[paddr[5:2]] <= pwdata;
		if (we_hi || we_lo)
		begin
			if (we_hi)
				cbuf[wr_blk][31:16] <= wr_word[31:16];
			if (we_lo)
				cbuf[wr_blk][15:0] <= wr_word[15:0];
		end
		else if (wr_go && is_buf)
			cbuf[paddr[5:2]] <= pwdata;
	end
endmodule
`default_nettype wire

//--- test/timeslot_prescaler_capture_properties.sv
// Concurrent checks on the prescaler, bus and capture ports
`timescale 1ns/10ps
`default_nettype none
module capture_block_checker (
	input wire logic clk, // Clock
	input wire logic rstn, // Reset, low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Write
	input wire logic [15:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [5:0] capture_inputs, // Pins
	input wire logic cap_irq, // Interrupt
	input wire logic slot_tick // Tick
);
	logic wr;
	logic clr;
	logic [4:0] psc;
	logic [21:0] ctl;
	logic [1:0] seen;
	logic [7:0] gap;
	logic [7:0] base;
	logic [7:0] div;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Committed writes mirrored, so no read-back is needed
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign clr = wr && (paddr == 16'h1048 || paddr == 16'h1044);
	assign base = psc[3:0] == 4'h0 ? 8'h02 : {4'h0, psc[3:0]} + 8'h01;
	assign div = psc[4] ? base : {base[4:0], 3'h0};
	// Spacing trusted only from the third tick after a divide change
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			psc <= 5'h00;
			ctl <= 22'h00_0000;
			seen <= 2'h0;
			gap <= 8'h00;
		end
		else
		begin
			gap <= slot_tick ? 8'h00 : gap + 8'h01;
			if (wr && paddr == 16'h1040)
			begin
				psc <= pwdata[4:0];
				seen <= 2'h0;
			end
			else if (slot_tick && seen != 2'h2)
				seen <= seen + 2'h1;
			if (wr && paddr == 16'h1044)
				ctl <= pwdata[21:0];
		end
	end
	a_tick_single: assert property (slot_tick |=> !slot_tick)
		else $error("slot tick longer than one cycle");
	a_tick_spacing: assert property (slot_tick && seen == 2'h2 |-> gap == div - 8'h01)
		else $error("tick spacing differs from divide setting");
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error without ready or with data");
	a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	a_irq_on_edge: assert property (
		|(capture_inputs & ~$past(capture_inputs) & ctl[5:0] & ctl[21:16]) |-> ##[2:10] cap_irq)
		else $error("enabled edge raised no interrupt");
	a_irq_hold: assert property ($fell(cap_irq) |-> $past(clr, 2) || $past(clr, 3))
		else $error("interrupt dropped without a clear");
endmodule
bind timeslot_prescaler_capture capture_block_checker chk_u (.clk(clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .capture_inputs(capture_inputs), .cap_irq(cap_irq),
	.slot_tick(slot_tick));
`default_nettype wire

//--- test/capture_pin_source.sv
// External pin source pulsing the six capture inputs
`timescale 1ns/10ps
`default_nettype none
module capture_pin_source (
	input wire logic clk, // Clock
	input wire logic [5:0] fire, // Pins to raise
	input wire logic [3:0] hold, // Extra cycles held high
	output logic [5:0] capture_inputs // Pin levels
);
	logic [3:0] cnt = 4'h0;
	logic [5:0] lvl = 6'h00;
	// One driver for the pins: the pulse register below
	assign capture_inputs = lvl;
	// Pulses last hold plus one cycles; single-cycle pulses are missed by the synchroniser
	always @(posedge clk)
	begin
		if (|fire)
		begin
			lvl <= lvl | fire;
			cnt <= hold;
		end
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else
			lvl <= 6'h00;
	end
endmodule
`default_nettype wire

//--- test/timeslot_prescaler_capture_tb.sv
// Self-checking bench for registers, prescaler, captures and step mode
`timescale 1ns/10ps
`default_nettype none
module timeslot_prescaler_capture_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] pins;
	logic [5:0] fire = 6'h00;
	logic [3:0] hold = 4'h2;
	logic cap_irq;
	logic slot_tick;
	logic [31:0] rd;
	logic err;
	logic [31:0] ent [5] = '{32'h0000_0003, 32'hfff0_0009, 32'h0000_0003, 32'hfff0_0009,
		32'hfff0_000a};
	bit ded;
	bit bf;
	int error_cnt = 0;
	int checks = 0;
	int tk = 0;
	int ev;
	int t0;
	int i;
	int m;
	timeslot_prescaler_capture dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_inputs(pins), .cap_irq(cap_irq), .slot_tick(slot_tick));
	capture_pin_source pin_u (.clk(clk), .fire(fire), .hold(hold), .capture_inputs(pins));
	always #2.5 clk = ~clk;
	// Tick model counts prescaler periods
	always @(posedge clk)
		if (slot_tick === 1'b1)
			tk <= tk + 1;
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// One transfer, then an idle edge so psel is never driven twice at once
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input string n, input logic [15:0] a, input logic [31:0] k,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(n, rd & k, exp);
	endtask
	task automatic wait_tick(output int g);
		g = 0;
		do
		begin
			@(posedge clk);
			g++;
		end while (slot_tick !== 1'b1);
	endtask
	// Expected overall divide for a five-bit prescaler code
	function automatic int div_of(input int v);
		return (v % 16 == 0 ? 2 : v % 16 + 1) * (v > 15 ? 1 : 8);
	endfunction
	task automatic finish_test;
		$display("error_cnt %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog, several times the expected run length
	initial
	begin
		#400000;
		error_cnt++;
		finish_test;
	end
	initial
	begin
		void'($urandom(32'h3210_7895));
		repeat (2)
			@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// Refused accesses leave the divide untouched
		apb(1'b1, 16'h1042, 32'h0000_0011);
		check("misaligned", 32'(err), 32'h0000_0001);
		apb(1'b0, 16'h1000, 32'h0000_0000);
		check("unmapped", 32'(err), 32'h0000_0001);
		rdchk("presc", 16'h1040, 32'h0000_001f, 32'h0000_0000);
		rdchk("ptr", 16'h104c, 32'h0000_001f, 32'h0000_001f);
		// Every prescaler code, settled tick spacing
		for (i = 0; i < 32; i++)
		begin
			apb(1'b1, 16'h1040, 32'(i));
			rdchk("presc", 16'h1040, 32'h0000_001f, 32'(i));
			repeat (4)
				wait_tick(m);
			check("tick gap", 32'(m), 32'(div_of(i)));
		end
		// Each pin in both modes; model tracks event count and destination
		apb(1'b0, 16'h1054, 32'h0000_0000);
		ev = rd[31:24];
		for (m = 0; m < 2; m++)
		begin
			apb(1'b1, 16'h1044, m ? 32'h013f_003f : 32'h023f_003f);
			for (i = 0; i < 6; i++)
			begin
				ded = i < (m ? 4 : 2);
				bf = !ded && (i < 5 || m == 0);
				apb(1'b0, 16'h104c, 32'h0000_0000);
				t0 = rd[4:0];
				hold <= 4'($urandom_range(5, 2));
				fire <= 6'(1 << i);
				@(posedge clk);
				fire <= 6'h00;
				repeat (12)
					@(posedge clk);
				ev = i == 5 ? (ev + 1) % 256 : ev;
				rdchk("flag", 16'h1048, 32'h0000_003f, 32'(1 << i));
				check("irq", 32'(cap_irq), 32'h0000_0001);
				apb(1'b0, 16'h104c, 32'h0000_0000);
				check("ptr moved", 32'(rd[4:0] != t0), 32'(bf));
				apb(1'b0, 16'(ded ? 16'h1080 + 4 * i : 16'h1100 + 2 * (rd[4:0] & 5'h1e)), rd);
				if (ded || bf)
					check("pin id", 32'(rd[23:20]), 32'(i > 1 ? 1 << (i - 2) : 0));
				if ((ded || bf) && i < 5)
					check("count", 32'(rd[31:24]), 32'(ev));
				apb(1'b1, 16'h1048, 32'h0000_003f);
				@(posedge clk);
				check("irq clear", 32'(cap_irq), 32'h0000_0000);
			end
		end
		rdchk("events", 16'h1054, 32'hff00_0000, 32'(ev) << 24);
		apb(1'b1, 16'h104c, 32'h0000_0009);
		rdchk("ptr write", 16'h104c, 32'h0000_001f, 32'h0000_0009);
		// Command captures fill half-words; a pin capture may reuse the block of the last one
		apb(1'b1, 16'h1200, 32'h0000_0004);
		apb(1'b1, 16'h1050, 32'h0001_000f);
		repeat (40)
			@(posedge clk);
		apb(1'b1, 16'h1050, 32'h0000_000f);
		apb(1'b0, 16'h104c, 32'h0000_0000);
		check("last16", 32'(rd[8]), 32'h0000_0001);
		t0 = rd[4:0];
		fire <= 6'h10;
		@(posedge clk);
		fire <= 6'h00;
		repeat (12)
			@(posedge clk);
		rdchk("reuse", 16'h104c, 32'h0000_011f, 32'(t0 % 2 ? t0 : (t0 + 3) % 32));
		// Steps at entries 0 and 2, timers at 1, 3, 4; end set to next-to-last
		apb(1'b1, 16'h1040, 32'h0000_0000);
		for (i = 0; i < 5; i++)
			apb(1'b1, 16'(16'h1200 + 4 * i), ent[i]);
		apb(1'b1, 16'h1050, 32'h0001_030f);
		t0 = tk;
		repeat (1600)
			@(posedge clk);
		apb(1'b1, 16'h1050, 32'h0000_030f);
		t0 = tk - t0;
		for (i = 1; i < 5; i++)
		begin
			apb(1'b0, 16'(16'h1200 + 4 * i), 32'h0000_0000);
			m = (i == 1 ? 1 : 2) * rd[19:8] - t0;
			if (i != 2)
				check("rate", 32'(m >= -4 && m <= 2), 32'h1);
		end
		finish_test;
	end
endmodule
`default_nettype wire
